// ==== hdl/align_fsm.sv ====
// Fabric alignment partner that pulses slip until pattern matches
`timescale 1ns/100ps
`include "realign_regs.svh"
module align_fsm
	import realign_pkg::*;
	#(
	parameter int WORD_W = `WORD_W_DEF,
	parameter word_t PATTERN = `PATTERN_DEF
	)
	(
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	realign_if.fabric lnk,
	output logic locked,
	output word_t rx_word,
	output logic rx_valid
	);
	// ****************
	// Alignment state machine
	// ****************
	align_state_e st_q, st_d;
	word_t samp_q, samp_d;
	logic sv_q, sv_d;
	logic [3:0] tmr_q, tmr_d;
	logic [2:0] good_q, good_d;
	logic slip_gen_q, slip_gen_d;
	logic slip_out_q, slip_out_d;
	logic lock_q, lock_d;
	word_t mask;

	always_comb
	begin
		mask = word_t'((1 << WORD_W) - 1);
		// RULE10: register words first
		samp_d = lnk.data & mask;
		sv_d = lnk.data_valid;
		// RULE11: register the request
		slip_out_d = slip_gen_q;
		st_d = st_q;
		tmr_d = tmr_q;
		good_d = good_q;
		slip_gen_d = 1'b0;
		lock_d = lock_q;
		case (st_q)
			align_idle:
			begin
				lock_d = 1'b0;
				if (start)
				begin
					st_d = align_cmp;
					good_d = 3'h0;
				end
			end
			align_cmp:
			begin
				// RULE12: slip on mismatch
				if (sv_q && samp_q != (PATTERN & mask))
				begin
					st_d = align_high;
					tmr_d = 4'h1;
					slip_gen_d = 1'b1;
					good_d = 3'h0;
				end
				else if (sv_q)
				begin
					good_d = good_q + 3'h1;
					if (good_q + 3'h1 == `MATCH_NEED)
					begin
						st_d = align_locked;
					end
				end
			end
			align_high:
			begin
				// RULE8: high for two cycles
				slip_gen_d = 1'b1;
				tmr_d = tmr_q + 4'h1;
				if (tmr_q[2:0] == `SLIP_HIGH_CYC)
				begin
					slip_gen_d = 1'b0;
					st_d = align_low;
					tmr_d = 4'h1;
				end
			end
			align_low:
			begin
				// RULE9: low for three cycles
				tmr_d = tmr_q + 4'h1;
				if (tmr_q[2:0] == `SLIP_LOW_CYC)
				begin
					st_d = align_settle;
					tmr_d = 4'h0;
				end
			end
			align_settle:
			begin
				tmr_d = tmr_q + 4'h1;
				if (tmr_q == `SETTLE_CYC)
				begin
					st_d = align_cmp;
				end
			end
			align_locked:
			begin
				lock_d = 1'b1;
				if (start)
				begin
					st_d = align_cmp;
					lock_d = 1'b0;
					good_d = 3'h0;
				end
			end
			default:
			begin
				st_d = align_idle;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= align_idle;
			samp_q <= '0;
			sv_q <= 1'b0;
			tmr_q <= 4'h0;
			good_q <= 3'h0;
			slip_gen_q <= 1'b0;
			slip_out_q <= 1'b0;
			lock_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			samp_q <= samp_d;
			sv_q <= sv_d;
			tmr_q <= tmr_d;
			good_q <= good_d;
			slip_gen_q <= slip_gen_d;
			slip_out_q <= slip_out_d;
			lock_q <= lock_d;
		end
	end

	assign lnk.slip_req = slip_out_q;
	assign lnk.data_ready = 1'b1;
	assign locked = lock_q;
	assign rx_word = samp_q;
	assign rx_valid = sv_q;
endmodule

// ==== hdl/word_realigner.sv ====
// Per-channel receive word realigner with output buffer
`timescale 1ns/100ps
`include "realign_regs.svh"
module word_realigner
	import realign_pkg::*;
	#(
	parameter int WORD_W = `WORD_W_DEF,
	parameter bit SLIP_FROM_PIN = 1'b0
	)
	(
	input wire logic clk,
	input wire logic nrst,
	input wire word_t deser_word,
	input wire logic slip_pin,
	input wire logic slip_fabric_en,
	realign_if.device lnk,
	output logic [`SLIP_CNT_W-1:0] slip_count
	);
// Functional notes
// RULE1: Works on deserialized parallel words only
// RULE2: One independent realigner per channel instance
// RULE3: Each slip rising edge shifts one bit
// RULE4: Unused slip gives plain register delay
// RULE5: Word width 8 or 10 bits
// RULE6: Counter wraps past width minus one
// RULE7: New word next cycle, input never stalls
// RULE8: Partner holds request high two cycles
// RULE9: Partner holds request low three cycles
// RULE10: Partner registers received words first
// RULE11: Partner registers request before realigner
// RULE12: Partner slips again until pattern matches
// RULE13: Request from pin or fabric logic
// RULE14: Reader clock equal frequency, no flags
// RULE15: Slip counter resets to zero

	// ****************
	// Realign datapath
	// ****************
	localparam int CW = `SLIP_CNT_W;
	localparam logic [CW-1:0] LAST = CW'(WORD_W - 1);

	logic [WORD_W-1:0] reg2_q, reg2_d, reg3_q, reg3_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [2:0] pin_sync_q, pin_sync_d;
	logic edge_q, edge_d;
	logic req_q, req_d;
	word_t out_word;

	function automatic logic [WORD_W-1:0] pick
		(
		input logic [WORD_W-1:0] older,
		input logic [WORD_W-1:0] newer,
		input logic [CW-1:0] sh
		);
		logic [2*WORD_W-1:0] both;
		both = {newer, older};
		pick = WORD_W'(both >> sh);
	endfunction

	always_comb
	begin
		// RULE1: parallel words in
		reg3_d = deser_word[WORD_W-1:0];
		reg2_d = reg3_q;
		pin_sync_d = {pin_sync_q[1:0], slip_pin};
		// RULE13: source select
		if (SLIP_FROM_PIN)
		begin
			req_d = (pin_sync_q[2] == pin_sync_q[1]) ? pin_sync_q[2] : req_q;
		end
		else
		begin
			req_d = lnk.slip_req & slip_fabric_en;
		end
		edge_d = req_q;
		cnt_d = cnt_q;
		// RULE3: one bit per rising edge
		if (req_q && !edge_q)
		begin
			// RULE6: wrap past width minus one
			if (cnt_q == LAST)
			begin
				cnt_d = `SLIP_CNT_RST;
			end
			else
			begin
				cnt_d = cnt_q + CW'(1);
			end
		end
		out_word = '0;
		// RULE4: zero count is fixed delay
		if (cnt_q == `SLIP_CNT_RST)
		begin
			out_word[WORD_W-1:0] = reg3_q;
		end
		else
		begin
			out_word[WORD_W-1:0] = pick(reg2_q, reg3_q, cnt_q);
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg2_q <= '0;
			reg3_q <= '0;
			// RULE15: count starts at zero
			cnt_q <= `SLIP_CNT_RST;
			pin_sync_q <= '0;
			req_q <= 1'b0;
			edge_q <= 1'b0;
		end
		else
		begin
			reg2_q <= reg2_d;
			reg3_q <= reg3_d;
			cnt_q <= cnt_d;
			pin_sync_q <= pin_sync_d;
			req_q <= req_d;
			edge_q <= edge_d;
		end
	end

	// ****************
	// Two-entry output buffer
	// ****************
	word_t buf_q [2];
	word_t buf_d [2];
	logic [1:0] fill_q, fill_d;
	logic [`SLIP_CNT_W-1:0] cnt_out_q;
	logic pop;
	logic valid_q, valid_d;

	always_comb
	begin
		// RULE7: accept every cycle, overwrite oldest when full
		pop = (fill_q != 2'h0) && lnk.data_ready;
		buf_d = buf_q;
		fill_d = fill_q;
		if (pop)
		begin
			buf_d[0] = buf_q[1];
		end
		if (fill_q == 2'h2 && !pop)
		begin
			buf_d[0] = buf_q[1];
			buf_d[1] = out_word;
		end
		else if (pop)
		begin
			if (fill_q == 2'h1)
			begin
				buf_d[0] = out_word;
			end
			else
			begin
				buf_d[1] = out_word;
			end
		end
		else
		begin
			buf_d[fill_q[0]] = out_word;
			fill_d = fill_q + 2'h1;
		end
		valid_d = (fill_d != 2'h0);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			fill_q <= 2'h0;
			cnt_out_q <= `SLIP_CNT_RST;
			valid_q <= 1'b0;
		end
		else
		begin
			buf_q <= buf_d;
			fill_q <= fill_d;
			cnt_out_q <= cnt_d;
			valid_q <= valid_d;
		end
	end

	// RULE2: per-channel outputs
	assign lnk.data = buf_q[0];
	// RULE14: same clock, no full flag
	assign lnk.data_valid = valid_q;
	assign slip_count = cnt_out_q;
endmodule

// ==== pkg/realign_if.sv ====
// Link between the word realigner and the fabric alignment partner
`timescale 1ns/100ps
interface realign_if
	import realign_pkg::*;
	();
	word_t data;
	logic data_valid;
	logic data_ready;
	logic slip_req;
	modport device
	(
		output data,
		output data_valid,
		input data_ready,
		input slip_req
	);
	modport fabric
	(
		input data,
		input data_valid,
		output data_ready,
		output slip_req
	);
endinterface

// ==== pkg/realign_pkg.sv ====
// Types shared by the realigner and the alignment partner
`include "realign_regs.svh"
package realign_pkg;
	typedef logic [`WORD_W_MAX-1:0] word_t;
	typedef enum logic [2:0]
	{
		align_idle = 3'h0,
		align_cmp = 3'h1,
		align_high = 3'h2,
		align_low = 3'h3,
		align_settle = 3'h4,
		align_locked = 3'h5
	} align_state_e;
endpackage

// ==== pkg/realign_regs.svh ====
// Constants for the receive word realigner and its alignment partner
`ifndef REALIGN_REGS_SVH
`define REALIGN_REGS_SVH
`define WORD_W_MAX 10
`define WORD_W_DEF 10
`define SLIP_CNT_W 4
`define SLIP_CNT_RST 4'h0
`define SLIP_HIGH_CYC 3'h2
`define SLIP_LOW_CYC 3'h3
`define SETTLE_CYC 4'h6
`define MATCH_NEED 3'h4
`define PATTERN_DEF 10'h3E0
`endif

// ==== test/realign_properties.sv ====
// Link checks between the word realigner and its alignment partner
`timescale 1ns/100ps
`include "realign_regs.svh"
module realign_properties
	import realign_pkg::*;
	#(
	parameter word_t PATTERN = `PATTERN_DEF
	)
	(
	input wire logic clk,
	input wire logic nrst,
	input wire word_t data,
	input wire logic data_valid,
	input wire logic data_ready,
	input wire logic slip_req
	);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// *****
	// Link assertions
	// *****
	reset_quiet_a: assert property (disable iff (1'b0)
		!nrst |-> !data_valid && !slip_req) else $error("busy in reset");
	valid_start_a: assert property (
		$rose(nrst) |-> ##[1:2] data_valid) else $error("no word");
	valid_holds_a: assert property (
		data_valid |=> data_valid) else $error("stream gap");
	slip_high_a: assert property (
		$rose(slip_req) |=> slip_req) else $error("slip short");
	slip_low_a: assert property (
		$fell(slip_req) |-> !slip_req [*3]) else $error("gap short");
	slip_ends_a: assert property (
		$rose(slip_req) |-> ##[1:8] !slip_req) else $error("slip stuck");
	slip_moves_a: assert property (
		$rose(slip_req) |-> ##[2:6] $changed(data)) else $error("no shift");
	lock_quiet_a: assert property (
		(data == PATTERN) [*8] |-> !$rose(slip_req))
		else $error("slip on match");
endmodule

// ==== test/test_dpa_rx_word_realigner.sv ====
// Self-checking bench for the realigner and its alignment partner
`timescale 1ns/100ps
`include "realign_regs.svh"
module test_dpa_rx_word_realigner
	import realign_pkg::*;
	();
	typedef struct {word_t w; logic [3:0] n;} row_s;
	logic clk = 1'b1;
	logic nrst = 1'b1;
	logic start = 1'b0;
	word_t deser = 10'h000;
	logic locked;
	logic rx_valid;
	word_t rx_word;
	logic [3:0] cnt;
	logic [3:0] old;
	logic pin = 1'b0;
	logic [3:0] pin_cnt;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	row_s rows [4] = '{'{10'h3E0, 4'h0}, '{10'h307, 4'h3},
		'{10'h01F, 4'h5}, '{10'h1F0, 4'h9}};
	realign_if lnk();
	realign_if pin_lnk();
	assign pin_lnk.data_ready = 1'b1;
	assign pin_lnk.slip_req = 1'b0;
	word_realigner #(.SLIP_FROM_PIN(1'b1)) u_word_realigner_pin (.clk(clk),
		.nrst(nrst), .deser_word(deser), .slip_pin(pin),
		.slip_fabric_en(1'b0), .lnk(pin_lnk.device), .slip_count(pin_cnt));
	word_realigner u_word_realigner (.clk(clk), .nrst(nrst),
		.deser_word(deser), .slip_pin(1'b0), .slip_fabric_en(1'b1),
		.lnk(lnk.device), .slip_count(cnt));
	align_fsm u_align_fsm (.clk(clk), .nrst(nrst), .start(start),
		.lnk(lnk.fabric), .locked(locked), .rx_word(rx_word),
		.rx_valid(rx_valid));
	realign_properties u_realign_properties (.clk(clk), .nrst(nrst),
		.data(lnk.data), .data_valid(lnk.data_valid),
		.data_ready(lnk.data_ready), .slip_req(lnk.slip_req));
	always #20 clk = ~clk;
	// *****
	// Checking and run control
	// *****
	function automatic word_t rotr(input word_t w, input logic [3:0] k);
		return word_t'({w, w} >> k);
	endfunction
	task automatic chk(input string nm, input word_t got, input word_t exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic restart(input word_t w);
		nrst = 1'b0;
		deser = w;
		repeat (3) @(negedge clk);
		chk("count", {6'h00, cnt}, 10'h000);
		nrst = 1'b1;
		repeat (8) @(negedge clk);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	initial
	begin
		@(negedge clk);
		foreach (rows[i])
		begin
			restart(rows[i].w);
			for (int t = 0; t < 900 && locked !== 1'b1; t++)
				@(negedge clk);
			chk("locked", {9'h000, locked}, 10'h001);
			chk("valid", {9'h000, rx_valid}, 10'h001);
			chk("count", {6'h00, cnt}, {6'h00, rows[i].n});
			chk("word", rx_word, 10'h3E0);
		end
		restart(10'h001);
		for (int s = 0; s < 11; s++)
		begin
			old = cnt;
			for (int t = 0; t < 200 && cnt === old; t++)
				@(negedge clk);
			chk("count", {6'h00, cnt},
				(old == 4'h9) ? 10'h000 : {6'h00, old + 4'h1});
			chk("word", rx_word, rotr(10'h001, old));
		end
		chk("pin count", {6'h00, pin_cnt}, 10'h000);
		pin = 1'b1;
		repeat (4) @(negedge clk);
		pin = 1'b0;
		repeat (8) @(negedge clk);
		chk("pin count", {6'h00, pin_cnt}, 10'h001);
		chk("pin word", pin_lnk.data, rotr(10'h001, 4'h1));
		complete_run();
	end
endmodule
